// File: logic/coeff_loader_pkg.sv
// Shared constants and types for the FIR coefficient loader and its host
package coeff_loader_pkg;
    // Bus and coefficient geometry
    localparam int WORD_W = 16;
    localparam int COEFF_W = 27;
    localparam int MAX_COEFFS = 48;
    localparam int SLOT_W = 6;
    localparam int SUM_W = 16;
    localparam int PAD_BITS = 5;
    // Register addresses
    localparam logic [15:0] CTRL1_ADDR = 16'h0001;
    // Control register 1 fields
    localparam int ARM_BIT = 15;
    localparam int RD_STATUS_BIT = 11;
    localparam int TAP_SEL_LSB = 5;
    localparam int TAP_SEL_W = 4;
    localparam int SELF_CLEAR_LSB = 9;
    localparam logic [15:0] CTRL1_RESET = 16'h001a;
    // Status register field
    localparam int MATCH_BIT = 7;
    // Coefficients per odd tap-count step
    localparam int COEFF_STEP = 6;
    // Core clock is 200 MHz; the internal clock is core divided by this
    localparam int DIVIDED_CORE_CLOCK_DIV = 2;
    // Zero-fill takes half an internal clock period per slot
    localparam int FILL_CYCLES_PER_SLOT = (DIVIDED_CORE_CLOCK_DIV / 2 > 0) ? DIVIDED_CORE_CLOCK_DIV / 2 : 1;
    // Host write sequence states
    typedef enum logic [2:0] {
        H_IDLE, H_ADDR, H_CTRL, H_HI, H_LO, H_SUM, H_WAIT
    } host_state_t;
endpackage

// File: logic/coeff_bus_if.sv
// Parallel 16-bit write/read bus between host and converter
`timescale 1ns/1ps
interface coeff_bus_if;
    logic wr_strobe; // One-cycle write strobe from host
    logic [15:0] wr_data; // Write word
    logic rd_strobe; // One-cycle read strobe from host
    logic [15:0] rd_data; // Read word from device
    logic rd_valid; // Read word valid pulse
    modport device (input wr_strobe, input wr_data, input rd_strobe,
                    output rd_data, output rd_valid);
    modport host (output wr_strobe, output wr_data, output rd_strobe,
                  input rd_data, input rd_valid);
endinterface

// File: logic/coeff_loader_device.sv
// Converter-side FIR coefficient download engine with checksum check
//
// Overview of operation
// - Host pads 27-bit coefficient to 32 bits
// - Upper word then lower word per coefficient
// - Word after last coefficient is checksum
// - Checksum is 16-bit sum of all bytes
// - Match flag at status bit 7 on equality
// - Host arms load with tap count together
// - Store coefficients outward from symmetry centre
// - Host repeats upper/lower pairs for all coefficients
// - Tap code: zero default, odd codes 6..48
// - Coefficient RAM is cleared by reset
// - Zero unused slots, half internal clock each
// - Host writes address 0x0001 then data
// - Match flag readable by status and data
// - Read-status bit returns status next read
// - After arm, writes are coefficient words
// - Control bits 15 to 9 self-clear
`timescale 1ns/1ps
module coeff_loader_device (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    coeff_bus_if.device bus,
    input wire logic [23:0] conv_data_i,
    input wire logic [5:0] coeff_rd_addr_i,
    output logic [26:0] coeff_rd_data_o,
    output logic custom_filter_o,
    output logic [3:0] tap_count_select_o,
    output logic load_checksum_match_o,
    output logic load_busy_o
);
    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {D_IDLE, D_CTRL, D_HI, D_LO, D_SUM, D_FILL} dev_state_t;
    dev_state_t state; // Write decoder state
    logic [15:0] ctrl1; // Control register 1 image
    logic [26:0] coeff_ram [0:coeff_loader_pkg::MAX_COEFFS-1]; // Coefficient store
    logic [5:0] slot; // Next slot to store or zero
    logic [5:0] n_coeffs; // Coefficients expected this load
    logic [15:0] upper_word; // Held first half of a coefficient
    logic [15:0] sum; // Running byte sum
    logic load_checksum_match; // Status bit
    logic status_pending; // Next read returns status
    logic divided_core_clock; // Internal clock phase enable
    logic [1:0] fill_cnt; // Cycles within one zero-fill slot
    logic [15:0] next_sum; // Sum after adding one word's bytes
    logic [5:0] next_count; // Coefficient count from tap code

    // ---------------------------------------------------------------
    // Tap code decode and byte sum
    // ---------------------------------------------------------------
    // Odd codes map to (code+1)/2 steps of six; others fall back to default
    always_comb begin
        logic [3:0] code;
        code = bus.wr_data[coeff_loader_pkg::TAP_SEL_LSB +: coeff_loader_pkg::TAP_SEL_W];
        if (code[0]) begin
            next_count = 6'(({2'h0, code} + 6'h01) >> 1) * 6'(coeff_loader_pkg::COEFF_STEP);
        end else begin
            next_count = 6'h00;
        end
    end

    // Every coefficient word contributes its two bytes to the 16-bit sum
    assign next_sum = sum + {8'h00, bus.wr_data[15:8]} + {8'h00, bus.wr_data[7:0]};

    // Internal clock: one enable pulse per divided period
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            divided_core_clock <= 1'b0;
        end else begin
            divided_core_clock <= ~divided_core_clock;
        end
    end

    // ---------------------------------------------------------------
    // Write decoder state machine
    // ---------------------------------------------------------------
    // An address word precedes every register write
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            state <= D_IDLE;
            slot <= 6'h00;
            n_coeffs <= 6'h00;
            upper_word <= 16'h0000;
            sum <= 16'h0000;
            fill_cnt <= 2'h0;
        end else begin
            case (state)
                // Waiting for a register address
                D_IDLE: begin
                    if (bus.wr_strobe && bus.wr_data == coeff_loader_pkg::CTRL1_ADDR) begin
                        state <= D_CTRL;
                    end
                end
                // Control data: arming diverts later writes into coefficients
                D_CTRL: begin
                    if (bus.wr_strobe) begin
                        if (bus.wr_data[coeff_loader_pkg::ARM_BIT]) begin
                            n_coeffs <= next_count;
                            slot <= 6'h00;
                            sum <= 16'h0000;
                            state <= (next_count == 6'h00) ? D_SUM : D_HI;
                        end else begin
                            state <= D_IDLE;
                        end
                    end
                end
                // Upper word of a coefficient
                D_HI: begin
                    if (bus.wr_strobe) begin
                        upper_word <= bus.wr_data;
                        sum <= next_sum;
                        state <= D_LO;
                    end
                end
                // Lower word completes the coefficient
                D_LO: begin
                    if (bus.wr_strobe) begin
                        sum <= next_sum;
                        slot <= slot + 6'h01;
                        state <= (slot + 6'h01 == n_coeffs) ? D_SUM : D_HI;
                    end
                end
                // Checksum word is compared, not stored
                D_SUM: begin
                    if (bus.wr_strobe) begin
                        fill_cnt <= 2'h0;
                        state <= D_FILL;
                    end
                end
                // Zero remaining slots at half an internal clock each
                D_FILL: begin
                    if (slot >= 6'(coeff_loader_pkg::MAX_COEFFS)) begin
                        state <= D_IDLE;
                    end else if (32'(fill_cnt) + 1 >= coeff_loader_pkg::FILL_CYCLES_PER_SLOT) begin
                        fill_cnt <= 2'h0;
                        slot <= slot + 6'h01;
                    end else begin
                        fill_cnt <= fill_cnt + 2'h1;
                    end
                end
                default: state <= D_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Coefficient storage
    // ---------------------------------------------------------------
    // Volatile store: reset wipes every slot
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < coeff_loader_pkg::MAX_COEFFS; i++) begin
                coeff_ram[i] <= 27'h0000000;
            end
        end else if (state == D_LO && bus.wr_strobe) begin
            coeff_ram[slot] <= {upper_word[10:0], bus.wr_data};
        end else if (state == D_FILL && slot < 6'(coeff_loader_pkg::MAX_COEFFS)) begin
            coeff_ram[slot] <= 27'h0000000;
        end
    end

    // Read port for the filter datapath
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            coeff_rd_data_o <= 27'h0000000;
        end else if (coeff_rd_addr_i < 6'(coeff_loader_pkg::MAX_COEFFS)) begin
            coeff_rd_data_o <= coeff_ram[coeff_rd_addr_i];
        end else begin
            coeff_rd_data_o <= 27'h0000000;
        end
    end

    // ---------------------------------------------------------------
    // Control register and status
    // ---------------------------------------------------------------
    // Bits 15..9 never persist; they act once on the write
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            ctrl1 <= coeff_loader_pkg::CTRL1_RESET;
        end else if (state == D_CTRL && bus.wr_strobe) begin
            ctrl1 <= {7'h00, bus.wr_data[8:0]};
        end
    end

    // Match flag: cleared on arm, set on checksum equality
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            load_checksum_match <= 1'b0;
        end else if (state == D_SUM && bus.wr_strobe) begin
            load_checksum_match <= (bus.wr_data == sum);
        end else if (state == D_CTRL && bus.wr_strobe && bus.wr_data[coeff_loader_pkg::ARM_BIT]) begin
            load_checksum_match <= 1'b0;
        end
    end

    // Read-status request is a one-shot for the next read
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            status_pending <= 1'b0;
        end else if (state == D_CTRL && bus.wr_strobe) begin
            status_pending <= bus.wr_data[coeff_loader_pkg::RD_STATUS_BIT];
        end else if (bus.rd_strobe) begin
            status_pending <= 1'b0;
        end
    end

    // Read answer: status word, or conversion data with the flag attached
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            bus.rd_data <= 16'h0000;
            bus.rd_valid <= 1'b0;
        end else begin
            bus.rd_valid <= bus.rd_strobe;
            if (bus.rd_strobe && status_pending) begin
                bus.rd_data <= 16'(load_checksum_match) << coeff_loader_pkg::MATCH_BIT;
            end else if (bus.rd_strobe) begin
                bus.rd_data <= {conv_data_i[23:9], load_checksum_match};
            end
        end
    end

    assign custom_filter_o = (n_coeffs != 6'h00);
    assign tap_count_select_o = ctrl1[coeff_loader_pkg::TAP_SEL_LSB +: coeff_loader_pkg::TAP_SEL_W];
    assign load_checksum_match_o = load_checksum_match;
    assign load_busy_o = (state != D_IDLE) && (state != D_CTRL);
endmodule

// File: logic/coeff_loader_host.sv
// Host-side sequencer: download a coefficient set, then check it
`timescale 1ns/1ps
module coeff_loader_host (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    coeff_bus_if.host bus,
    input wire logic start_i,
    input wire logic [3:0] tap_count_select_i,
    input wire logic [4:0] low_ctrl_i,
    input wire logic [26:0] coeff_i,
    output logic [5:0] coeff_idx_o,
    output logic done_o,
    output logic ok_o
);
    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    coeff_loader_pkg::host_state_t state; // Sequencer state
    logic verify; // Second pass reads status
    logic [5:0] n_coeffs; // Coefficients to send
    logic [15:0] sum; // Running byte sum
    logic [7:0] wait_cnt; // Zero-fill wait counter
    logic [31:0] padded; // Coefficient padded to 32 bits
    logic [15:0] ctrl_word; // Control data for current pass
    logic rd_wait; // Waiting for status read answer

    // Five zero bits above sign and magnitude
    assign padded = {5'h00, coeff_i};
    assign ctrl_word = verify ?
        {4'h0, 1'b1, 2'h0, tap_count_select_i, low_ctrl_i} :
        {1'b1, 6'h00, tap_count_select_i, low_ctrl_i};

    // ---------------------------------------------------------------
    // Write sequencer
    // ---------------------------------------------------------------
    // One write per cycle; the device takes words back to back
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            state <= coeff_loader_pkg::H_IDLE;
            verify <= 1'b0;
            n_coeffs <= 6'h00;
            sum <= 16'h0000;
            wait_cnt <= 8'h00;
            coeff_idx_o <= 6'h00;
            bus.wr_strobe <= 1'b0;
            bus.wr_data <= 16'h0000;
            bus.rd_strobe <= 1'b0;
            rd_wait <= 1'b0;
            done_o <= 1'b0;
            ok_o <= 1'b0;
        end else begin
            bus.wr_strobe <= 1'b0;
            bus.rd_strobe <= 1'b0;
            done_o <= 1'b0;
            case (state)
                // Start a download on request
                coeff_loader_pkg::H_IDLE: begin
                    if (rd_wait && bus.rd_valid) begin
                        rd_wait <= 1'b0;
                        ok_o <= bus.rd_data[coeff_loader_pkg::MATCH_BIT];
                        done_o <= 1'b1;
                    end else if (start_i && !rd_wait) begin
                        verify <= 1'b0;
                        n_coeffs <= tap_count_select_i[0] ?
                            6'((tap_count_select_i + 5'h01) >> 1) * 6'(6) : 6'h00;
                        state <= coeff_loader_pkg::H_ADDR;
                    end
                end
                // Register address precedes data
                coeff_loader_pkg::H_ADDR: begin
                    bus.wr_strobe <= 1'b1;
                    bus.wr_data <= coeff_loader_pkg::CTRL1_ADDR;
                    state <= coeff_loader_pkg::H_CTRL;
                end
                coeff_loader_pkg::H_CTRL: begin
                    bus.wr_strobe <= 1'b1;
                    bus.wr_data <= ctrl_word;
                    sum <= 16'h0000;
                    coeff_idx_o <= 6'h00;
                    if (verify) begin
                        state <= coeff_loader_pkg::H_IDLE;
                        rd_wait <= 1'b1;
                    end else begin
                        state <= (n_coeffs == 6'h00) ?
                            coeff_loader_pkg::H_SUM : coeff_loader_pkg::H_HI;
                    end
                end
                // Upper then lower word per coefficient
                coeff_loader_pkg::H_HI: begin
                    bus.wr_strobe <= 1'b1;
                    bus.wr_data <= padded[31:16];
                    sum <= sum + {8'h00, padded[31:24]} + {8'h00, padded[23:16]};
                    state <= coeff_loader_pkg::H_LO;
                end
                coeff_loader_pkg::H_LO: begin
                    bus.wr_strobe <= 1'b1;
                    bus.wr_data <= padded[15:0];
                    sum <= sum + {8'h00, padded[15:8]} + {8'h00, padded[7:0]};
                    coeff_idx_o <= coeff_idx_o + 6'h01;
                    state <= (coeff_idx_o + 6'h01 == n_coeffs) ?
                        coeff_loader_pkg::H_SUM : coeff_loader_pkg::H_HI;
                end
                // Checksum follows the last coefficient
                coeff_loader_pkg::H_SUM: begin
                    bus.wr_strobe <= 1'b1;
                    bus.wr_data <= sum;
                    wait_cnt <= 8'(coeff_loader_pkg::MAX_COEFFS + 4);
                    state <= coeff_loader_pkg::H_WAIT;
                end
                // Hold off while the device zero-fills
                coeff_loader_pkg::H_WAIT: begin
                    if (wait_cnt == 8'h00) begin
                        verify <= 1'b1;
                        state <= coeff_loader_pkg::H_ADDR;
                    end else begin
                        wait_cnt <= wait_cnt - 8'h01;
                    end
                end
                default: state <= coeff_loader_pkg::H_IDLE;
            endcase
            // Issue the status read one cycle after the verify control write
            if (state == coeff_loader_pkg::H_IDLE && rd_wait && !bus.rd_valid
                         && !bus.rd_strobe) begin
                bus.rd_strobe <= 1'b1;
            end
        end
    end
endmodule

// File: verification/coeff_bus_sva.sv
// Concurrent checks on the host-to-converter coefficient bus
`timescale 1ns/1ps
module coeff_bus_sva (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic wr_strobe,
    input wire logic [15:0] wr_data,
    input wire logic rd_strobe,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    // ------------------------------------------------------------
    // Shadow of the write sequence seen on the wire
    // ------------------------------------------------------------
    logic addr_seen; // Address word just written
    logic loading; // Coefficient words still expected
    logic hi; // Next coefficient word is the upper half
    logic exp_match; // Our own checksum verdict
    logic status_pend; // Next read should return status
    logic [6:0] words_left; // Up to 96 words
    logic [5:0] cur_n; // Coefficients of the armed load
    logic [5:0] fill_cnt; // Cycles of zero fill still running
    logic [15:0] sum; // Independent byte sum
    logic [5:0] ncoef; // Count decoded from a control word
    assign ncoef = wr_data[5] ? 6'((wr_data[8:5] + 1) / 2 * 6) : 6'h00;
    // Decode writes; the checksum word ends a load and fixes the verdict
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            {addr_seen, loading, hi, exp_match, status_pend} <= 5'h00;
            words_left <= 7'h00;
            cur_n <= 6'h00;
            sum <= 16'h0000;
        end else begin
            if (rd_strobe) begin
                status_pend <= 1'b0;
            end
            if (wr_strobe && loading && words_left != 7'h00) begin
                sum <= sum + 16'(wr_data[15:8]) + 16'(wr_data[7:0]);
                words_left <= words_left - 7'h01;
                hi <= !hi;
            end else if (wr_strobe && loading) begin
                exp_match <= (sum == wr_data);
                loading <= 1'b0;
            end else if (wr_strobe && addr_seen) begin
                addr_seen <= 1'b0;
                status_pend <= wr_data[11];
                if (wr_data[15]) begin
                    loading <= 1'b1;
                    words_left <= {ncoef, 1'b0};
                    cur_n <= ncoef;
                    hi <= 1'b1;
                    sum <= 16'h0000;
                    exp_match <= 1'b0;
                end
            end else if (wr_strobe) begin
                addr_seen <= (wr_data == coeff_loader_pkg::CTRL1_ADDR);
            end
        end
    end
    // Zero fill window: one core cycle per unused slot
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            fill_cnt <= 6'h00;
        end else if (wr_strobe && loading && words_left == 7'h00) begin
            fill_cnt <= 6'h30 - cur_n;
        end else if (fill_cnt != 6'h00) begin
            fill_cnt <= fill_cnt - 6'h01;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    rd_answer_a: assert property (rd_strobe |=> rd_valid)
        else $error("read not answered next cycle");
    rd_no_spurious_a: assert property (rd_valid |-> $past(rd_strobe))
        else $error("read valid without request");
    rd_hold_a: assert property (!rd_valid |-> $stable(rd_data))
        else $error("read word changed without a read");
    hi_pad_a: assert property (wr_strobe && loading && words_left != 7'h00 && hi
        |-> wr_data[15:11] == 5'h00) else $error("upper word padding not zero");
    arm_code_a: assert property (wr_strobe && addr_seen && wr_data[15]
        |-> wr_data[5] || wr_data[8:5] == 4'h0) else $error("arm with unlisted tap code");
    addr_first_a: assert property (wr_strobe && !loading && !addr_seen
        |-> wr_data == coeff_loader_pkg::CTRL1_ADDR) else $error("write not addressed");
    fill_quiet_a: assert property (fill_cnt != 6'h00 |-> !wr_strobe)
        else $error("write during zero fill");
    status_flag_a: assert property (rd_valid && $past(status_pend)
        |-> rd_data[coeff_loader_pkg::MATCH_BIT] == exp_match) else $error("bad status flag");
    data_flag_a: assert property (rd_valid && !$past(status_pend)
        |-> rd_data[0] == exp_match) else $error("bad flag in data read");
    cover property (wr_strobe && addr_seen && wr_data[8:5] == 4'hf);
    cover property (wr_strobe && loading && words_left == 7'h00);
    cover property (rd_valid && $past(status_pend) && rd_data[7]);
endmodule

// File: verification/tb_top.sv
// Testbench: host-to-converter pair plus a bench-driven converter
`timescale 1ns/1ps
module tb_top;
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic reset_b_n = 1'b0; // Reset of the driven converter
    logic start = 1'b0;
    logic [3:0] tap_sel = 4'h0;
    logic [5:0] raddr = 6'h00, raddr_b = 6'h00;
    logic [5:0] idx;
    logic [31:0] cw;
    logic done, ok, custom, match, busy, custom_b, match_b, busy_b;
    logic [3:0] tap_o, tap_b;
    logic [26:0] rdat, rdat_b;
    logic [15:0] d;
    logic [23:0] conv = 24'h5a3c96; // Fixed conversion word
    int fails = 0;
    int n_checks = 0;
    // Known-good set; beyond it a simple index pattern
    logic [31:0] tab [12] = '{32'h032b9688, 32'h01bf183c, 32'h00156626, 32'h04a81e6a,
        32'h045f2a96, 32'h002c49c2, 32'h0050e9f6, 32'h0010dbd8, 32'h042fde54,
        32'h0437445a, 32'h041b7d6e, 32'h04043b5f};
    coeff_bus_if bus ();
    coeff_bus_if bus_b ();
    function automatic logic [31:0] word_of(int i);
        return (i < 12) ? tab[i] : {5'h00, i[0], 10'(i), 16'(i * 4951)};
    endfunction
    function automatic logic [15:0] csum(int n);
        logic [15:0] s;
        logic [31:0] w;
        s = 16'h0000;
        for (int i = 0; i < n; i++) begin
            w = word_of(i);
            s = s + 16'(w[31:24]) + 16'(w[23:16]) + 16'(w[15:8]) + 16'(w[7:0]);
        end
        return s;
    endfunction
    assign cw = word_of(int'(idx));
    coeff_loader_host u_coeff_loader_host (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .bus(bus), .start_i(start), .tap_count_select_i(tap_sel), .low_ctrl_i(5'h19),
        .coeff_i(cw[26:0]), .coeff_idx_o(idx), .done_o(done), .ok_o(ok));
    coeff_loader_device u_coeff_loader_device (.core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i), .bus(bus), .conv_data_i(conv), .coeff_rd_addr_i(raddr),
        .coeff_rd_data_o(rdat), .custom_filter_o(custom), .tap_count_select_o(tap_o),
        .load_checksum_match_o(match), .load_busy_o(busy));
    // Bench-driven converter for rule-breaking cases
    coeff_loader_device u_coeff_loader_device_b (.core_clk_i(core_clk_i),
        .reset_n_i(reset_b_n), .bus(bus_b), .conv_data_i(conv), .coeff_rd_addr_i(raddr_b),
        .coeff_rd_data_o(rdat_b), .custom_filter_o(custom_b), .tap_count_select_o(tap_b),
        .load_checksum_match_o(match_b), .load_busy_o(busy_b));
    coeff_bus_sva u_coeff_bus_sva (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .wr_strobe(bus.wr_strobe), .wr_data(bus.wr_data), .rd_strobe(bus.rd_strobe),
        .rd_data(bus.rd_data), .rd_valid(bus.rd_valid));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        if (fails == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic tick;
        @(posedge core_clk_i);
        #1;
    endtask
    // Strobe drops for a cycle between words
    task automatic wr(input logic [15:0] w);
        bus_b.wr_data = w;
        bus_b.wr_strobe = 1'b1;
        tick();
        bus_b.wr_strobe = 1'b0;
        tick();
    endtask
    task automatic rd(output logic [15:0] v);
        bus_b.rd_strobe = 1'b1;
        tick();
        bus_b.rd_strobe = 1'b0;
        check("rd_valid", 32'(bus_b.rd_valid), 32'h1);
        v = bus_b.rd_data;
        tick();
    endtask
    task automatic ram_b(input logic [5:0] s, input logic [26:0] exp);
        raddr_b = s;
        tick();
        check("ram_b", 32'(rdat_b), 32'(exp));
    endtask
    task automatic dl_b(input logic [3:0] code, input int n, input logic [15:0] bad);
        logic [31:0] w;
        wr(coeff_loader_pkg::CTRL1_ADDR);
        wr(16'h8019 | (16'(code) << 5));
        for (int i = 0; i < n; i++) begin
            w = word_of(i);
            wr(w[31:16]);
            wr(w[15:0]);
        end
        wr(csum(n) ^ bad);
        repeat (50) tick();
    endtask
    // Status read, then a plain data read
    task automatic reads_b(input logic m);
        wr(coeff_loader_pkg::CTRL1_ADDR);
        wr(16'h0839);
        rd(d);
        check("status", 32'(d[7]), 32'(m));
        rd(d);
        check("conv", 32'(d), {16'h0000, conv[23:9], m});
    endtask
    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    initial begin
        bus_b.wr_strobe = 1'b0;
        bus_b.wr_data = 16'h0000;
        bus_b.rd_strobe = 1'b0;
        repeat (16) @(posedge core_clk_i);
        #1;
        reset_n_i = 1'b1;
        reset_b_n = 1'b1;
        check("tap_reset", 32'(tap_b), 32'h0);
        check("match_reset", 32'(match_b), 32'h0);
        // Every listed odd tap code through the real host
        for (int c = 1; c < 16; c += 2) begin
            tap_sel = 4'(c);
            start = 1'b1;
            tick();
            start = 1'b0;
            for (int k = 0; k < 2000 && done !== 1'b1; k++) begin
                tick();
                if (k == 1999) begin
                    fails++;
                    wrap_up();
                end
            end
            check("ok", 32'(ok), 32'h1);
            check("match", 32'(match), 32'h1);
            check("tap", 32'(tap_o), 32'(c));
            check("custom", 32'(custom), 32'h1);
            check("busy", 32'(busy), 32'h0);
            for (int s = 0; s < 48; s++) begin
                raddr = 6'(s);
                tick();
                check("ram", 32'(rdat), s < c * 3 + 3 ? word_of(s) : 0);
            end
        end
        // Unaddressed write is ignored
        wr(16'h0002);
        wr(16'h8039);
        check("busy_refused", 32'(busy_b), 32'h0);
        // Wrong checksum, then right one
        dl_b(4'h1, 6, 16'h0001);
        check("match_bad", 32'(match_b), 32'h0);
        reads_b(1'b0);
        dl_b(4'h1, 6, 16'h0000);
        check("match_good", 32'(match_b), 32'h1);
        ram_b(6'h05, 27'(word_of(5)));
        ram_b(6'h06, 27'h0);
        reads_b(1'b1);
        // Arm clears the flag; even code skips to the checksum
        wr(coeff_loader_pkg::CTRL1_ADDR);
        wr(16'h8019);
        check("match_armed", 32'(match_b), 32'h0);
        check("busy_armed", 32'(busy_b), 32'h1);
        wr(16'h0000);
        repeat (50) tick();
        check("match_default", 32'(match_b), 32'h1);
        check("custom_default", 32'(custom_b), 32'h0);
        ram_b(6'h00, 27'h0);
        // Reset after a good load discards it
        dl_b(4'h1, 6, 16'h0000);
        reset_b_n = 1'b0;
        repeat (2) tick();
        reset_b_n = 1'b1;
        ram_b(6'h00, 27'h0);
        check("match_rst", 32'(match_b), 32'h0);
        wrap_up();
    end
endmodule
